/* ssp_device.sv */
// Device end of the serial configuration port: frames, decodes and
// answers register transfers. Assumes a register file on mclk on the
// user side that answers a read request on the next cycle.
`include "ssp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ssp_device
  import ssp_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      reset,
  ssp_if.dev             link,
  input  wire logic      four_wire_select,
  output logic           reg_wr,
  output logic           reg_rd_req,
  output ssp_addr_t      reg_addr,
  output ssp_data_t      reg_wdata,
  input  wire ssp_data_t reg_rd_data,
  output logic           busy
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] sclk_s;
  logic [1:0] en_s;
  logic [1:0] sdio_s;

  always_ff @(posedge mclk) begin
    if (reset) begin
      sclk_s <= 3'h0;
      en_s   <= 2'h3;
      sdio_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      en_s   <= {en_s[0], link.serial_enable_n};
      sdio_s <= {sdio_s[0], link.sdio_line};
    end
  end

  wire sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire sclk_fall = ~sclk_s[1] & sclk_s[2];
  wire frame_on  = ~en_s[1];
  wire sdio_bit  = sdio_s[1];

  ////////////////////////////////////////////////////////////////////////
  // Frame state
  ssp_dev_state_t state;
  ssp_dev_state_t next_state;
  ssp_cnt_t       cnt;
  logic [23:0]    shin;
  ssp_data_t      shout;
  logic           four_wire;
  logic           rd_op;
  logic           rd_load;

  wire [23:0] next_shin  = {shin[22:0], sdio_bit};
  wire        instr_done = sclk_rise &&
                           (cnt == `SSP_INSTR_LEN - `SSP_CNT_ONE);
  wire        frame_done = sclk_rise &&
                           (cnt == `SSP_FRAME_LEN - `SSP_CNT_ONE);
  wire        rd_window  = (cnt >= `SSP_FIRST_RD_BIT) &&
                           (cnt <= `SSP_LAST_RD_BIT);
  wire        rd_launch  = sclk_fall && rd_op && rd_window &&
                           state == SSP_DEV_SHIFT;
  wire        rd_final   = sclk_fall && rd_op &&
                           cnt == `SSP_FRAME_LEN &&
                           state == SSP_DEV_DONE;
  wire        instr_rd   = next_shin[`SSP_INSTR_LEN - `SSP_CNT_ONE];

  always_comb begin
    next_state = state;
    case (state)
      SSP_DEV_IDLE: begin
        if (frame_on) begin
          next_state = SSP_DEV_SHIFT;
        end
      end
      SSP_DEV_SHIFT: begin
        if (!frame_on) begin
          next_state = SSP_DEV_IDLE;
        end else if (frame_done) begin
          next_state = SSP_DEV_DONE;
        end
      end
      SSP_DEV_DONE: begin
        if (!frame_on) begin
          next_state = SSP_DEV_IDLE;
        end else if (rd_final) begin
          next_state = SSP_DEV_HOLD;
        end
      end
      SSP_DEV_HOLD: begin
        if (!frame_on) begin
          next_state = SSP_DEV_IDLE;
        end
      end
      default: begin
        next_state = SSP_DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= SSP_DEV_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit counter and input shifter
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt  <= `SSP_CNT_ZERO;
      shin <= `SSP_FRAME_ZERO;
    end else if (state == SSP_DEV_IDLE) begin
      cnt  <= `SSP_CNT_ZERO;
      shin <= `SSP_FRAME_ZERO;
    end else if (sclk_rise && state == SSP_DEV_SHIFT) begin
      cnt  <= cnt + `SSP_CNT_ONE;
      shin <= next_shin;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode capture and instruction decode
  always_ff @(posedge mclk) begin
    if (reset) begin
      four_wire <= 1'b0;
      rd_op     <= 1'b0;
    end else if (state == SSP_DEV_IDLE && frame_on) begin
      four_wire <= four_wire_select;
      rd_op     <= 1'b0;
    end else if (instr_done && state == SSP_DEV_SHIFT) begin
      rd_op     <= instr_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // User-side register access
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_wr     <= 1'b0;
      reg_rd_req <= 1'b0;
      rd_load    <= 1'b0;
      reg_addr   <= `SSP_ADDR_ZERO;
      reg_wdata  <= `SSP_DATA_ZERO;
    end else begin
      rd_load    <= reg_rd_req;
      reg_rd_req <= 1'b0;
      reg_wr     <= 1'b0;
      if (instr_done && state == SSP_DEV_SHIFT) begin
        reg_addr   <= next_shin[6:0];
        reg_rd_req <= instr_rd;
      end
      if (frame_done && state == SSP_DEV_SHIFT && !rd_op) begin
        reg_wdata <= next_shin[`SSP_DATA_MSB:0];
        reg_wr    <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data output shifter
  always_ff @(posedge mclk) begin
    if (reset) begin
      shout <= `SSP_DATA_ZERO;
    end else if (rd_load) begin
      shout <= reg_rd_data;
    end else if (rd_launch) begin
      shout <= {shout[14:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers; enables are active low
  always_ff @(posedge mclk) begin
    if (reset) begin
      link.dev_sdio_o               <= 1'b0;
      link.dev_sdio_oe_n            <= 1'b1;
      link.dev_serial_data_out_o    <= 1'b0;
      link.dev_serial_data_out_oe_n <= 1'b1;
    end else if (!frame_on || state == SSP_DEV_IDLE) begin
      link.dev_sdio_oe_n            <= 1'b1;
      link.dev_serial_data_out_oe_n <= 1'b1;
    end else if (rd_final) begin
      link.dev_sdio_o               <= 1'b0;
      link.dev_sdio_oe_n            <= 1'b0;
      link.dev_serial_data_out_o    <= 1'b0;
      link.dev_serial_data_out_oe_n <= 1'b0;
    end else if (rd_launch) begin
      if (four_wire) begin
        link.dev_serial_data_out_o    <= shout[`SSP_DATA_MSB];
        link.dev_serial_data_out_oe_n <= 1'b0;
        link.dev_sdio_oe_n            <= 1'b1;
      end else begin
        link.dev_sdio_o               <= shout[`SSP_DATA_MSB];
        link.dev_sdio_oe_n            <= 1'b0;
        link.dev_serial_data_out_oe_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      busy <= 1'b0;
    end else begin
      busy <= (next_state != SSP_DEV_IDLE);
    end
  end

endmodule // ssp_device
`default_nettype wire

/* ssp_cfg.svh */
// Timing and framing constants of the serial configuration port.
// Assumes inclusion by the device and host ends of the port; definitions only.
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

`define SSP_MCLK_PERIOD_NS  5
`define SSP_SCLK_PERIOD_NS  80
`define SSP_SCLK_HALF_CYC   (`SSP_SCLK_PERIOD_NS / (2 * `SSP_MCLK_PERIOD_NS))
`define SSP_INSTR_LEN       5'h08
`define SSP_FRAME_LEN       5'h18
`define SSP_FIRST_RD_BIT    5'h08
`define SSP_LAST_RD_BIT     5'h17
`define SSP_CNT_ZERO        5'h00
`define SSP_CNT_ONE         5'h01
`define SSP_RW_POS          23
`define SSP_ADDR_HI         22
`define SSP_ADDR_LO         16
`define SSP_DATA_MSB        15
`define SSP_DATA_ZERO       16'h0000
`define SSP_ADDR_ZERO       7'h00
`define SSP_FRAME_ZERO      24'h00_0000

`endif

/* ssp_pkg.sv */
// Types shared by both ends of the serial configuration port.
// Assumes ssp_cfg.svh holds the numeric constants.
package ssp_pkg;
  typedef logic [6:0]  ssp_addr_t;
  typedef logic [15:0] ssp_data_t;
  typedef logic [4:0]  ssp_cnt_t;
  typedef enum logic [1:0] {
    SSP_DEV_IDLE, SSP_DEV_SHIFT, SSP_DEV_DONE, SSP_DEV_HOLD
  } ssp_dev_state_t;
  typedef enum logic [1:0] {
    SSP_HOST_IDLE, SSP_HOST_RUN, SSP_HOST_TAIL, SSP_HOST_GAP
  } ssp_host_state_t;
endpackage

/* ssp_if.sv */
// Serial link between host and device ends.
// Assumes an idle data pin is pulled high; both ends use active-low enables.
`timescale 1ns/1ps
`default_nettype none
interface ssp_if;
  logic sclk;
  logic serial_enable_n;
  logic host_sdio_o;
  logic host_sdio_oe_n;
  logic dev_sdio_o;
  logic dev_sdio_oe_n;
  logic dev_serial_data_out_o;
  logic dev_serial_data_out_oe_n;
  logic sdio_line;
  logic serial_data_out;

  // Resolved pin levels; undriven pins read high
  assign sdio_line       = !dev_sdio_oe_n ? dev_sdio_o :
                           (!host_sdio_oe_n ? host_sdio_o : 1'b1);
  assign serial_data_out = !dev_serial_data_out_oe_n ?
                           dev_serial_data_out_o : 1'b1;

  modport dev (
    input  sclk, serial_enable_n, sdio_line,
    output dev_sdio_o, dev_sdio_oe_n, dev_serial_data_out_o,
           dev_serial_data_out_oe_n
  );
  modport host (
    output sclk, serial_enable_n, host_sdio_o, host_sdio_oe_n,
    input  sdio_line, serial_data_out
  );
endinterface
`default_nettype wire

/* ssp_host.sv */
// Host end of the serial configuration port: runs one 24-bit frame per
// command. Assumes a device end as in ssp_device on the same link.
`include "ssp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ssp_host
  import ssp_pkg::*;
#(
  parameter int HALF_CYC = `SSP_SCLK_HALF_CYC
)(
  input  wire logic      mclk,
  input  wire logic      reset,
  ssp_if.host            link,
  input  wire logic      four_wire_select,
  input  wire logic      cmd_valid,
  output logic           cmd_ready,
  input  wire logic      cmd_read,
  input  wire ssp_addr_t cmd_addr,
  input  wire ssp_data_t cmd_wdata,
  output logic           rsp_valid,
  output ssp_data_t      rsp_rdata
);

  ////////////////////////////////////////////////////////////////////////
  // Read pin synchronisers
  logic [1:0] sdio_s;
  logic [1:0] out_s;

  always_ff @(posedge mclk) begin
    if (reset) begin
      sdio_s <= 2'h3;
      out_s  <= 2'h3;
    end else begin
      sdio_s <= {sdio_s[0], link.sdio_line};
      out_s  <= {out_s[0], link.serial_data_out};
    end
  end

  wire rd_pin = four_wire_select ? out_s[1] : sdio_s[1];

  ////////////////////////////////////////////////////////////////////////
  // Clock divider and frame sequencer
  ssp_host_state_t state;
  logic [15:0]     div;
  ssp_cnt_t        bitn;
  logic [23:0]     shout;
  logic            rd_op;

  wire        tick     = (div == 16'(HALF_CYC - 1));
  wire [23:0] next_out = {shout[22:0], 1'b0};
  wire        last_bit = (bitn == `SSP_FRAME_LEN - `SSP_CNT_ONE);
  wire        to_data  = (bitn == `SSP_INSTR_LEN - `SSP_CNT_ONE);

  always_ff @(posedge mclk) begin
    if (reset || state == SSP_HOST_IDLE || tick) begin
      div <= 16'h0000;
    end else begin
      div <= div + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state                <= SSP_HOST_IDLE;
      cmd_ready            <= 1'b1;
      rsp_valid            <= 1'b0;
      rsp_rdata            <= `SSP_DATA_ZERO;
      bitn                 <= `SSP_CNT_ZERO;
      shout                <= `SSP_FRAME_ZERO;
      rd_op                <= 1'b0;
      link.sclk            <= 1'b0;
      link.serial_enable_n <= 1'b1;
      link.host_sdio_o     <= 1'b0;
      link.host_sdio_oe_n  <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        SSP_HOST_IDLE: begin
          if (cmd_valid) begin
            cmd_ready            <= 1'b0;
            rd_op                <= cmd_read;
            shout                <= {cmd_read, cmd_addr, cmd_wdata};
            link.host_sdio_o     <= cmd_read;
            link.host_sdio_oe_n  <= 1'b0;
            link.serial_enable_n <= 1'b0;
            bitn                 <= `SSP_CNT_ZERO;
            state                <= SSP_HOST_RUN;
          end
        end
        SSP_HOST_RUN: begin
          if (tick && !link.sclk) begin
            link.sclk <= 1'b1;
            if (rd_op && bitn >= `SSP_FIRST_RD_BIT) begin
              rsp_rdata <= {rsp_rdata[14:0], rd_pin};
            end
          end else if (tick) begin
            link.sclk <= 1'b0;
            if (last_bit) begin
              state <= SSP_HOST_TAIL;
            end else begin
              bitn             <= bitn + `SSP_CNT_ONE;
              shout            <= next_out;
              link.host_sdio_o <= next_out[`SSP_RW_POS];
              if (rd_op && to_data) begin
                link.host_sdio_oe_n <= 1'b1;
              end
            end
          end
        end
        SSP_HOST_TAIL: begin
          if (tick) begin
            link.serial_enable_n <= 1'b1;
            link.host_sdio_oe_n  <= 1'b1;
            rsp_valid            <= 1'b1;
            state                <= SSP_HOST_GAP;
          end
        end
        SSP_HOST_GAP: begin
          if (tick) begin
            cmd_ready <= 1'b1;
            state     <= SSP_HOST_IDLE;
          end
        end
        default: begin
          state <= SSP_HOST_IDLE;
        end
      endcase
    end
  end

endmodule // ssp_host
`default_nettype wire

/* ssp_link_properties.sv */
// Concurrent checks on the serial link joining host and device ends.
// Assumes its inputs come straight from the ssp_if instance of the bench.
`timescale 1ns/1ps
`default_nettype none
module ssp_link_properties (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic serial_enable_n,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe_n,
  input wire logic dev_sdio_o,
  input wire logic dev_sdio_oe_n,
  input wire logic dev_serial_data_out_o,
  input wire logic dev_serial_data_out_oe_n,
  input wire logic sdio_line,
  input wire logic serial_data_out
);
  logic       sclk_d;
  logic [4:0] rise_cnt;
  logic       rd_frame;
  wire        sclk_rise = sclk && !sclk_d;
  wire        sclk_fall = !sclk && sclk_d;
  wire        dev_quiet = dev_sdio_oe_n && dev_serial_data_out_oe_n;
  wire        dev_low   = !dev_sdio_oe_n && !dev_serial_data_out_oe_n;

  // Counts serial clock rises within a frame; notes the direction bit
  always_ff @(posedge mclk) begin
    sclk_d <= sclk;
    if (reset || serial_enable_n)
      rise_cnt <= 5'h00;
    else if (sclk_rise)
      rise_cnt <= rise_cnt + 5'h01;
    if (reset)
      rd_frame <= 1'b0;
    else if (sclk_rise && !serial_enable_n && rise_cnt == 5'h00)
      rd_frame <= sdio_line;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_last_fall;
    rd_frame && rise_cnt == 5'h18 && sclk_fall;
  endsequence
  sequence s_end_low;
    dev_low && !sdio_line && !serial_data_out;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_idle_quiet: assert property (
    serial_enable_n [*8] |-> dev_quiet) else $error("device drives idle link");
  a_instr_first: assert property (
    !serial_enable_n && rise_cnt < 5'h08 |-> dev_quiet)
    else $error("device drives during instruction");
  a_write_quiet: assert property (
    !serial_enable_n && !rd_frame && rise_cnt != 5'h00 |-> dev_quiet)
    else $error("device drives in write frame");
  a_read_drives: assert property (
    !serial_enable_n && rd_frame && rise_cnt == 5'h0c |-> !dev_quiet)
    else $error("no read data driven");
  a_both_low: assert property (
    dev_low |-> !dev_sdio_o && !dev_serial_data_out_o)
    else $error("data pins not both low");
  a_no_clash: assert property (
    !(!host_sdio_oe_n && !dev_sdio_oe_n)) else $error("data pin contention");
  a_end_low: assert property (
    s_last_fall |-> ##[1:6] s_end_low) else $error("pins not low at read end");
  a_hold_low: assert property (
    rd_frame && $rose(serial_enable_n) |-> dev_low ##[1:6] dev_quiet)
    else $error("end of read not held or released");
  a_frame_len: assert property (
    $rose(serial_enable_n) |-> rise_cnt == 5'h18) else $error("frame length");
  a_host_setup: assert property (
    $rose(sclk) |-> $stable(host_sdio_o) && $stable(serial_enable_n))
    else $error("host data moves at rising clock");
endmodule // ssp_link_properties
`default_nettype wire

/* serial_config_port_tb.sv */
// Bench for the serial configuration port, both ends back to back.
// Assumes the ssp design files are compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module serial_config_port_tb
  import ssp_pkg::*;
;
  logic        mclk = 1'h0;
  logic        reset = 1'h1;
  logic        four_wire_select = 1'h0;
  logic        cmd_valid = 1'h0;
  logic        cmd_read = 1'h0;
  ssp_addr_t   cmd_addr = 7'h00;
  ssp_data_t   cmd_wdata = 16'h0000;
  logic        cmd_ready, rsp_valid, reg_wr, reg_rd_req, busy;
  ssp_data_t   rsp_rdata, reg_wdata, reg_rd_data, wr_data;
  ssp_addr_t   reg_addr, wr_addr;
  ssp_data_t   dev_mem [0:127];
  ssp_data_t   exp_mem [0:127];
  logic [23:0] fr_io, fr_o;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n_rd = 0;

  ssp_if link_bus ();
  ssp_host ssp_host_inst (.mclk(mclk), .reset(reset), .link(link_bus),
    .four_wire_select(four_wire_select), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  ssp_device ssp_device_inst (.mclk(mclk), .reset(reset), .link(link_bus),
    .four_wire_select(four_wire_select), .reg_wr(reg_wr),
    .reg_rd_req(reg_rd_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rd_data(reg_rd_data), .busy(busy));
  ssp_link_properties ssp_link_properties_inst (.mclk(mclk), .reset(reset),
    .sclk(link_bus.sclk), .serial_enable_n(link_bus.serial_enable_n),
    .host_sdio_o(link_bus.host_sdio_o),
    .host_sdio_oe_n(link_bus.host_sdio_oe_n),
    .dev_sdio_o(link_bus.dev_sdio_o), .dev_sdio_oe_n(link_bus.dev_sdio_oe_n),
    .dev_serial_data_out_o(link_bus.dev_serial_data_out_o),
    .dev_serial_data_out_oe_n(link_bus.dev_serial_data_out_oe_n),
    .sdio_line(link_bus.sdio_line),
    .serial_data_out(link_bus.serial_data_out));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  // Register file on the device user side
  assign reg_rd_data = dev_mem[reg_addr];
  always @(posedge mclk) begin
    if (reg_wr === 1'h1) begin
      dev_mem[reg_addr] <= reg_wdata;
      wr_addr <= reg_addr;
      wr_data <= reg_wdata;
    end
    if (reg_rd_req === 1'h1) begin
      n_rd <= n_rd + 1;
    end
  end

  // Both data lines as seen at each rising serial clock in a frame
  always @(posedge link_bus.sclk) begin
    if (link_bus.serial_enable_n === 1'h0) begin
      fr_io <= {fr_io[22:0], link_bus.sdio_line};
      fr_o <= {fr_o[22:0], link_bus.serial_data_out};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [23:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic xfer(input logic rd, input ssp_addr_t a, input ssp_data_t d);
    int         k;
    int         p;
    logic [2:0] lines;
    ssp_data_t  e;
    e = rd ? exp_mem[a] : d;
    p = n_rd;
    k = 0;
    @(negedge mclk);
    while (cmd_ready !== 1'h1 && k < 1000) begin
      @(negedge mclk);
      k++;
    end
    cmd_read = rd;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'h1;
    @(negedge mclk);
    cmd_valid = 1'h0;
    while (rsp_valid !== 1'h1 && k < 2000) begin
      @(negedge mclk);
      k++;
    end
    lines = {link_bus.sdio_line, link_bus.serial_data_out, busy};
    if (rd) begin
      check("read end low", 24'(lines[2:1]), 24'h00_0000);
    end
    repeat (4) @(negedge mclk);
    lines = {link_bus.sdio_line, link_bus.serial_data_out, busy};
    check("lines released", 24'(lines), 24'h00_0006);
    check("instruction", 24'(fr_io[23:16]), 24'({rd, a}));
    check("read requests", 24'(n_rd - p), 24'(rd));
    if (!rd) begin
      exp_mem[a] = d;
      check("write data", 24'(fr_io[15:0]), 24'(d));
      check("write register", 24'({wr_addr, wr_data}), 24'({a, d}));
    end else begin
      check("read data", 24'(rsp_rdata), 24'(e));
      if (four_wire_select) begin
        check("out pin data", 24'(fr_o[15:0]), 24'(e));
        check("sdio input only", 24'(fr_io[15:0]), 24'h00_ffff);
      end else begin
        check("sdio data", 24'(fr_io[15:0]), 24'(e));
        check("out pin released", fr_o, 24'hff_ffff);
      end
    end
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    repeat (20) @(negedge mclk);
    reset = 1'h0;
    for (int m = 0; m < 2; m++) begin
      @(negedge mclk);
      four_wire_select = m[0];
      xfer(1'h0, 7'h00, 16'ha5c3);
      xfer(1'h0, 7'h7f, 16'h0001);
      xfer(1'h0, 7'h2a, m[0] ? 16'hffff : 16'h8000);
      xfer(1'h1, 7'h7f, 16'h0000);
      xfer(1'h1, 7'h00, 16'h0000);
      xfer(1'h1, 7'h2a, 16'h0000);
      $display("test mode %0d done", m);
    end
    @(negedge mclk);
    reset = 1'h1;
    four_wire_select = 1'h0;
    repeat (3) @(negedge mclk);
    reset = 1'h0;
    check("reset idle", 24'({cmd_ready, busy}), 24'h00_0002);
    xfer(1'h1, 7'h00, 16'h0000);
    $display("test reset done");
    report_and_stop();
  end
endmodule // serial_config_port_tb
`default_nettype wire
